// ### adc_control_register_set.sv
// Converter control block: APB register set, conversion sequencer and analog control outputs
`timescale 1ns/100ps
`default_nettype none

module adc_control_register_set (
  // Clock, reset, enable
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_N,
  input  wire logic                       I_CE,
  // APB slave
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [7:0]                 I_PADDR,
  input  wire logic [31:0]                I_PWDATA,
  output logic      [31:0]                O_PRDATA,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  // Option storage and converter core
  input  wire logic [4:0]                 I_TRIM_OPTION,
  input  wire logic                       I_TRIM_LOAD,
  input  wire logic [11:0]                I_CONV_DATA,
  // Analog and pin controls
  output adc_regs_pkg::analog_ctrl_t      O_ANALOG,
  output adc_regs_pkg::pin_ctrl_t         O_PINS,
  output logic                            O_CONV_CLK_EN,
  output logic                            O_CONV_RESET,
  output logic                            O_EOC_REQ
);
  import adc_regs_pkg::*;

  typedef enum {S_IDLE, S_ARMED, S_SAMPLE, S_CONVERT} seq_t;

  // Registers
  logic [7:0]  ctrl_main;
  logic [7:0]  ctrl_aux;
  logic [7:0]  pin_sel;
  logic [7:0]  trim;
  logic [11:0] result;
  logic        busy;
  logic        trim_loaded;
  seq_t        state;
  logic [DIV_W-1:0] div_cnt;
  logic [4:0]  phase_cnt;
  logic        conv_tick;

  // Access decode
  logic wr_en;
  logic rd_en;
  assign wr_en = I_CE && I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en = I_CE && I_PSEL && I_PENABLE && !I_PWRITE;

  // Divider ratio minus one for a code; top bit set flags an undefined code
  function automatic logic [DIV_W:0] div_limit(input logic [2:0] code);
    case (code)
      3'h0:    div_limit = 6'h01;
      3'h1:    div_limit = 6'h07;
      3'h2:    div_limit = 6'h1F;
      3'h4:    div_limit = 6'h00;
      3'h5:    div_limit = 6'h03;
      3'h6:    div_limit = 6'h0F;
      default: div_limit = 6'h20;
    endcase
  endfunction : div_limit

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == ADDR_CTRL_MAIN) || (a == ADDR_CTRL_AUX) || (a == ADDR_PIN_SEL) ||
                 (a == ADDR_TRIM) || (a == ADDR_RES_LOW) || (a == ADDR_RES_HIGH);
  endfunction : addr_known

  logic [DIV_W:0] lim;
  logic           div_ok;
  logic           chan_ok;
  logic           powered;
  assign lim     = div_limit(ctrl_aux[2:0]);
  assign div_ok  = !lim[DIV_W];
  assign chan_ok = ctrl_main[2:0] <= CH_TREF;
  assign powered = !ctrl_main[POFF_BIT];

  // Main control: software bits; start edges drive the sequencer
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_main <= RST_CTRL_MAIN;
    end else if (I_CE && wr_en && I_PADDR == ADDR_CTRL_MAIN) begin
      ctrl_main <= {I_PWDATA[7], 1'b0, I_PWDATA[5:0]};
    end
  end

  // Aux control: sample-width status is held zero, test bit forced one
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_aux <= RST_CTRL_AUX;
    end else if (I_CE && wr_en && I_PADDR == ADDR_CTRL_AUX) begin
      ctrl_aux <= (I_PWDATA[7:0] & AUX_RW_MASK) | RST_CTRL_AUX;
    end
  end

  // Pin select: unimplemented bits never stored
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_sel <= RST_PIN_SEL;
    end else if (I_CE && wr_en && I_PADDR == ADDR_PIN_SEL) begin
      pin_sel <= I_PWDATA[7:0] & PIN_SEL_MASK;
    end
  end

  // Trim: option value once after reset, software may overwrite later
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trim        <= 8'h00;
      trim_loaded <= 1'b0;
    end else if (I_CE) begin
      if (!trim_loaded && I_TRIM_LOAD) begin
        trim        <= {3'h0, I_TRIM_OPTION};
        trim_loaded <= 1'b1;
      end else if (wr_en && I_PADDR == ADDR_TRIM) begin
        trim <= I_PWDATA[7:0] & TRIM_MASK;
      end
    end
  end

  // Converter clock divider; stopped on undefined code or power-off
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_cnt   <= '0;
      conv_tick <= 1'b0;
    end else if (I_CE) begin
      if (!div_ok || !powered || state == S_IDLE || state == S_ARMED) begin
        div_cnt   <= '0;
        conv_tick <= 1'b0;
      end else if (div_cnt >= lim[DIV_W-1:0]) begin
        div_cnt   <= '0;
        conv_tick <= 1'b1;
      end else begin
        div_cnt   <= div_cnt + 1'b1;
        conv_tick <= 1'b0;
      end
    end
  end

  // Sequencer: arm on start rise, run on start fall, sample then convert
  logic start_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_q   <= 1'b0;
      state     <= S_IDLE;
      busy      <= 1'b1;
      phase_cnt <= '0;
      O_EOC_REQ <= 1'b0;
    end else if (I_CE) begin
      start_q   <= ctrl_main[START_BIT];
      O_EOC_REQ <= 1'b0;
      case (state)
        S_IDLE: begin
          if (ctrl_main[START_BIT] && !start_q) begin
            state <= S_ARMED;
            busy  <= 1'b1;
          end
        end
        S_ARMED: begin
          if (!ctrl_main[START_BIT]) begin
            state     <= (powered && chan_ok && div_ok) ? S_SAMPLE : S_IDLE;
            phase_cnt <= '0;
          end
        end
        S_SAMPLE: begin
          if (conv_tick) begin
            if (phase_cnt == SAMPLE_CLKS - 5'h01) begin
              state     <= S_CONVERT;
              phase_cnt <= '0;
            end else begin
              phase_cnt <= phase_cnt + 5'h01;
            end
          end
        end
        S_CONVERT: begin
          if (conv_tick) begin
            if (phase_cnt == CONVERT_CLKS - 5'h01) begin
              state     <= S_IDLE;
              busy      <= 1'b0;
              O_EOC_REQ <= 1'b1;
            end else begin
              phase_cnt <= phase_cnt + 5'h01;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
      if (ctrl_main[START_BIT] && !start_q && state != S_IDLE) begin
        state     <= S_ARMED;
        busy      <= 1'b1;
        O_EOC_REQ <= 1'b0;  // Restart aborts a finishing conversion, no stale request
      end
      if (!powered) begin
        state <= S_IDLE;
      end
    end
  end

  // Result capture; cleared while powered off
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result <= '0;
    end else if (I_CE) begin
      if (!powered) begin
        result <= '0;
      end else if (state == S_CONVERT && conv_tick && phase_cnt == CONVERT_CLKS - 5'h01) begin
        result <= I_CONV_DATA;
      end
    end
  end

  // Analog control outputs, registered
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ANALOG      <= '0;
      O_PINS        <= '0;
      O_CONV_CLK_EN <= 1'b0;
      O_CONV_RESET  <= 1'b1;
    end else if (I_CE) begin
      O_ANALOG.channel_onehot      <= chan_ok ? (6'h01 << ctrl_main[2:0]) : 6'h00;
      O_ANALOG.prebuffer_on        <= ctrl_main[MODE_BIT] && powered;
      O_ANALOG.prebuffer_gain      <= (ctrl_main[2:0] != CH_TEMP) ? GAIN_1X :
                                      (ctrl_aux[GAIN_BIT] ? GAIN_4X : GAIN_2X);
      O_ANALOG.bypass_to_pin       <= ctrl_main[BYS_BIT];
      O_ANALOG.tref_to_pin         <= ctrl_main[2:0] == CH_TREF;
      O_ANALOG.reference_select    <= ctrl_aux[VREF_BIT];
      O_ANALOG.opamp_supply_select <= ctrl_aux[OPAV_BIT];
      O_ANALOG.temp_sensor_enable  <= pin_sel[TSE_BIT];
      O_ANALOG.temp_trim           <= trim[4:0];
      O_ANALOG.powered             <= powered;
      O_PINS.pa1_analog            <= pin_sel[PA1_BIT];
      O_PINS.pb0_analog            <= pin_sel[PB0_BIT];
      O_PINS.pa1_pullup_off        <= pin_sel[PA1_BIT];
      O_PINS.pb0_pullup_off        <= pin_sel[PB0_BIT];
      O_CONV_CLK_EN                <= div_ok && powered && chan_ok;
      O_CONV_RESET                 <= state == S_ARMED || state == S_IDLE;
    end
  end

  // APB read data and response, zero wait
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA  <= '0;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY  <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_known(I_PADDR);
      O_PRDATA  <= '0;
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        case (I_PADDR)
          ADDR_CTRL_MAIN: O_PRDATA <= {24'h0, ctrl_main[7], busy, ctrl_main[5:0]};
          ADDR_CTRL_AUX:  O_PRDATA <= {24'h0, ctrl_aux};
          ADDR_PIN_SEL:   O_PRDATA <= {24'h0, pin_sel};
          ADDR_TRIM:      O_PRDATA <= {24'h0, trim};
          ADDR_RES_LOW:   O_PRDATA <= {24'h0, result[3:0], 4'h0};
          ADDR_RES_HIGH:  O_PRDATA <= {24'h0, result[11:4]};
          default:        O_PRDATA <= '0;
        endcase
      end
    end
  end

  // Checks
  a_busy_after_start: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && ctrl_main[START_BIT] && !start_q ##1 I_CE |-> busy)
    else $error("busy not set after start rise");
  a_result_cleared_off: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && !powered |=> result == 12'h000)
    else $error("result not cleared while off");
  a_eoc_clears_busy: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_EOC_REQ |-> !busy && state == S_IDLE)
    else $error("request without busy clear");
  a_aux_test_one: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == ADDR_CTRL_AUX |=>
      O_PRDATA[TEST_BIT] && !O_PRDATA[SMPW_BIT])
    else $error("aux test bit or width status wrong");
  a_pin_unused_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == ADDR_PIN_SEL |=>
      (O_PRDATA[7:0] & ~PIN_SEL_MASK) == 8'h00)
    else $error("unused pin-select bits set");
  a_trim_upper_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == ADDR_TRIM |=>
      (O_PRDATA[7:0] & ~TRIM_MASK) == 8'h00)
    else $error("unused trim bits set");
  a_gain_other_1x: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && ctrl_main[2:0] != CH_TEMP |=> O_ANALOG.prebuffer_gain == GAIN_1X)
    else $error("gain not 1X");
  a_no_tick_bad_div: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && !div_ok |=> !conv_tick)
    else $error("converter clock runs on bad code");
  a_sample_to_conv: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && $rose(state == S_CONVERT) |->
      $past(state) == S_SAMPLE && $past(phase_cnt) == SAMPLE_CLKS - 5'h01)
    else $error("sample phase length wrong");
  // Pulse, power, read-path, channel and sequencer checks
  a_eoc_one_cycle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && O_EOC_REQ |=> !O_EOC_REQ)
    else $error("end-of-conversion request longer than one cycle");
  a_off_no_prebuffer: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && !powered |=> !O_ANALOG.prebuffer_on && !O_ANALOG.powered)
    else $error("pre-buffer on while converter off");
  a_result_low_nibble: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == ADDR_RES_LOW |=>
      O_PRDATA[3:0] == 4'h0)
    else $error("result low nibble not zero");
  a_bad_chan_no_clk: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && !chan_ok |=> !O_CONV_CLK_EN && O_ANALOG.channel_onehot == 6'h00)
    else $error("converter clock or source on undefined channel");
  a_armed_holds_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && state == S_ARMED |=> O_CONV_RESET)
    else $error("converter not held in reset while armed");
  a_busy_in_convert: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && (state == S_SAMPLE || state == S_CONVERT) |-> busy)
    else $error("busy low while conversion runs");
  c_conv_done: cover property (@(posedge I_CLK) O_EOC_REQ);
  c_converting: cover property (@(posedge I_CLK) state == S_CONVERT && conv_tick);
  c_armed:     cover property (@(posedge I_CLK) state == S_ARMED);
  c_power_off: cover property (@(posedge I_CLK) !powered && result == 12'h000);
endmodule : adc_control_register_set

`default_nettype wire

// ### adc_regs_pkg.sv
// Package: register map, field layout and timing constants of the converter control block
package adc_regs_pkg;

  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL_MAIN = 8'h00;
  localparam logic [7:0] ADDR_CTRL_AUX  = 8'h04;
  localparam logic [7:0] ADDR_PIN_SEL   = 8'h08;
  localparam logic [7:0] ADDR_TRIM      = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h10;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h14;

  // Main control field positions
  localparam int START_BIT = 7;
  localparam int BUSY_BIT  = 6;
  localparam int POFF_BIT  = 5;
  localparam int MODE_BIT  = 4;
  localparam int BYS_BIT   = 3;
  // Aux control field positions
  localparam int TEST_BIT  = 7;
  localparam int GAIN_BIT  = 6;
  localparam int SMPW_BIT  = 5;
  localparam int VREF_BIT  = 4;
  localparam int OPAV_BIT  = 3;
  // Pin select field positions
  localparam int TSE_BIT   = 7;
  localparam int PA1_BIT   = 1;
  localparam int PB0_BIT   = 0;

  // Reset values and write masks
  localparam logic [7:0] RST_CTRL_MAIN = 8'h60;
  localparam logic [7:0] RST_CTRL_AUX  = 8'h80;
  localparam logic [7:0] RST_PIN_SEL   = 8'h03;
  localparam logic [7:0] PIN_SEL_MASK  = 8'h83;
  localparam logic [7:0] TRIM_MASK     = 8'h1F;
  localparam logic [7:0] AUX_RW_MASK   = 8'h5F;

  // Channel codes
  localparam logic [2:0] CH_AN0  = 3'h0;
  localparam logic [2:0] CH_AN1  = 3'h1;
  localparam logic [2:0] CH_OPA  = 3'h2;
  localparam logic [2:0] CH_REGULATOR_VOLTAGE_PIN = 3'h3;
  localparam logic [2:0] CH_TEMP = 3'h4;
  localparam logic [2:0] CH_TREF = 3'h5;

  // Gain codes on the pre-buffer
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_2X = 2'h1;
  localparam logic [1:0] GAIN_4X = 2'h2;

  // Conversion phase lengths in converter clocks, and divider counter width
  localparam logic [4:0] SAMPLE_CLKS  = 5'h04;
  localparam logic [4:0] CONVERT_CLKS = 5'h0C;
  localparam logic [4:0] SMP_SHORT    = 5'h02;
  localparam int         DIV_W        = 5;

  // Analog-side controls travel together
  typedef struct packed {
    logic [5:0] channel_onehot;
    logic       prebuffer_on;
    logic [1:0] prebuffer_gain;
    logic       bypass_to_pin;
    logic       tref_to_pin;
    logic       reference_select;
    logic       opamp_supply_select;
    logic       temp_sensor_enable;
    logic [4:0] temp_trim;
    logic       powered;
  } analog_ctrl_t;

  typedef struct packed {
    logic pa1_analog;
    logic pb0_analog;
    logic pa1_pullup_off;
    logic pb0_pullup_off;
  } pin_ctrl_t;

endpackage : adc_regs_pkg

// ### adc_control_register_set_bench.sv
// Self-checking bench for the converter control register set
`timescale 1ns/100ps
`default_nettype none

module adc_control_register_set_bench;
  import adc_regs_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trim_load = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] conv_data = 12'hABC;
  analog_ctrl_t analog;
  pin_ctrl_t   pins;
  logic        clk_en;
  logic        conv_reset;
  logic        eoc;
  int          failures = 0;
  int          tests_run = 0;
  logic [7:0]  rd;
  logic        err;

  adc_control_register_set dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TRIM_OPTION(5'h15), .I_TRIM_LOAD(trim_load), .I_CONV_DATA(conv_data),
    .O_ANALOG(analog), .O_PINS(pins), .O_CONV_CLK_EN(clk_en),
    .O_CONV_RESET(conv_reset), .O_EOC_REQ(eoc)
  );

  // 250 MHz system clock
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, exp});
  endtask : rdchk

  // Reset values, trim load and unmapped access
  task automatic t_reset_values;
    rdchk(ADDR_CTRL_MAIN, 8'h60);
    rdchk(ADDR_CTRL_AUX, 8'h80);
    rdchk(ADDR_PIN_SEL, 8'h03);
    rdchk(ADDR_TRIM, 8'h15);
    chk(analog.temp_trim, 5'h15);
    chk(analog.temp_sensor_enable, 1'b0);
    chk(analog.powered, 1'b0);
    rdchk(ADDR_RES_HIGH, 8'h00);
    apb(1'b0, 8'h18, 8'h00);
    chk({rd, err}, 9'h001);
  endtask : t_reset_values

  // Read-only and unimplemented bits ignore writes
  task automatic t_access;
    apb(1'b1, ADDR_CTRL_AUX, 8'h7F);
    rdchk(ADDR_CTRL_AUX, 8'hDF);
    apb(1'b1, ADDR_PIN_SEL, 8'h7E);
    rdchk(ADDR_PIN_SEL, 8'h02);
    repeat (2) @(posedge clk);
    chk(pins, 4'b1010);
    apb(1'b1, ADDR_PIN_SEL, 8'h81);
    repeat (2) @(posedge clk);
    chk(pins, 4'b0101);
    chk(analog.temp_sensor_enable, 1'b1);
    chk({analog.reference_select, analog.opamp_supply_select}, 2'b11);
    apb(1'b1, ADDR_TRIM, 8'hEA);
    rdchk(ADDR_TRIM, 8'h0A);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h3F);
    rdchk(ADDR_CTRL_MAIN, 8'h7F);
    apb(1'b1, ADDR_RES_LOW, 8'hFF);
    rdchk(ADDR_RES_LOW, 8'h00);
  endtask : t_access

  // Every channel code with gain bit set and pre-buffer on
  task automatic t_routing;
    for (int ch = 0; ch < 8; ch++) begin
      apb(1'b1, ADDR_CTRL_AUX, 8'h44);
      apb(1'b1, ADDR_CTRL_MAIN, 8'h18 | ch[7:0]);
      repeat (2) @(posedge clk);
      chk(analog.channel_onehot, (ch < 6) ? (6'h01 << ch) : 6'h00);
      chk(analog.prebuffer_gain, (ch == 4) ? GAIN_4X : GAIN_1X);
      chk(analog.tref_to_pin, ch == 5);
      chk({analog.prebuffer_on, analog.bypass_to_pin, analog.powered}, 3'b111);
      chk(clk_en, ch < 6);
    end
    apb(1'b1, ADDR_CTRL_AUX, 8'h04);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h04);
    repeat (2) @(posedge clk);
    chk({analog.prebuffer_gain, analog.prebuffer_on, analog.bypass_to_pin}, GAIN_2X << 2);
  endtask : t_routing

  // Conversions at several divider ratios, timing and result layout
  task automatic t_convert;
    logic [2:0] code [6] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
    int         ratio [6] = '{1, 2, 4, 8, 16, 32};
    int         n;
    for (int i = 0; i < 6; i++) begin
      conv_data <= 12'hABC + 12'(i * 291);
      apb(1'b1, ADDR_CTRL_AUX, {5'h00, code[i]});
      apb(1'b1, ADDR_CTRL_MAIN, 8'h80);
      rdchk(ADDR_CTRL_MAIN, 8'hC0);
      chk(conv_reset, 1'b1);
      apb(1'b1, ADDR_CTRL_MAIN, 8'h00);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (eoc !== 1'b1 && n < 600);
      chk(n >= 16 * ratio[i] && n <= 16 * ratio[i] + 8, 1'b1);
      rdchk(ADDR_CTRL_MAIN, 8'h00);
      rdchk(ADDR_RES_HIGH, conv_data[11:4]);
      rdchk(ADDR_RES_LOW, {conv_data[3:0], 4'h0});
    end
  endtask : t_convert

  // Power-off clears results; undefined divider produces no result
  task automatic t_off_undefined;
    int n;
    apb(1'b1, ADDR_CTRL_MAIN, 8'h20);
    rdchk(ADDR_RES_HIGH, 8'h00);
    rdchk(ADDR_RES_LOW, 8'h00);
    apb(1'b1, ADDR_CTRL_AUX, 8'h03);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h80);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h00);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      if (eoc === 1'b1) n++;
    end
    chk({n[7:0], clk_en}, 9'h000);
    rdchk(ADDR_CTRL_MAIN, 8'h40);
  endtask : t_off_undefined

  // Clock enable low freezes an armed conversion and the bus
  task automatic t_clock_enable;
    int n;
    int seen;
    apb(1'b1, ADDR_CTRL_AUX, 8'h04);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h80);
    apb(1'b1, ADDR_CTRL_MAIN, 8'h00);
    ce   <= 1'b0;
    seen = 0;
    repeat (40) begin
      @(posedge clk);
      if (eoc !== 1'b0 || pready !== 1'b0) seen++;
    end
    ce <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (eoc !== 1'b1 && n < 100);
    chk(seen, 0);
    chk(n >= 16 && n <= 24, 1'b1);
    rdchk(ADDR_CTRL_MAIN, 8'h00);
  endtask : t_clock_enable

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Reset for six cycles, trim loads right after release
  initial begin
    repeat (6) @(posedge clk);
    rst_n     <= 1'b1;
    trim_load <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_values();
    t_access();
    t_routing();
    t_convert();
    t_off_undefined();
    t_clock_enable();
    complete_run();
  end

  // Watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #200000;
    failures++;
    complete_run();
  end

endmodule : adc_control_register_set_bench

`default_nettype wire
